// file: sdc_pkg.sv
package sdc_pkg;
    localparam int BANKS   = 8;
    localparam int BA_W    = 3;
    localparam int ADDR_W  = 14;
    localparam int DQ_W    = 8;
    localparam int MR_NUM  = 4;
    localparam int MAX_BL  = 8;
    localparam int AUTO_PRECHARGE_ADDR_BIT = 10;
    localparam int BURST_CHOP_ADDR_BIT     = 12;
    // command code is {ras_n, cas_n, we_n} while cs_n is low
    localparam logic [2:0] CMD_MODE_LOAD = 3'h0;
    localparam logic [2:0] CMD_REFRESH   = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    localparam logic [2:0] CMD_READ      = 3'h5;
    localparam logic [2:0] CMD_NOP       = 3'h7;
    // mode_reg_zero burst field
    localparam int         MR0_BL_LSB     = 0;
    localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
    localparam logic [1:0] BL_ON_THE_FLY  = 2'h1;
    localparam logic [1:0] BL_FIXED_CHOP  = 2'h2;
    localparam int         MR1_TERM_BIT   = 2;
    localparam int         MR1_TSTRB_BIT  = 11;
    localparam logic [ADDR_W-1:0] MR_RST  = 14'h0000;
    localparam logic [3:0] BURST_OF_EIGHT = 4'h8;
    localparam logic [3:0] CHOP_OF_FOUR   = 4'h4;
    localparam int MCLK_NS     = 20;
    localparam int CK_HALF_NS  = 80;
    localparam int CK_HALF_CYC = (CK_HALF_NS + MCLK_NS - 1) / MCLK_NS;
    typedef enum logic [3:0] {
        PW_ON      = 4'h1,
        PW_PRE_PD  = 4'h2,
        PW_ACT_PD  = 4'h4,
        PW_SELF    = 4'h8
    } sdc_pwr_t;
    typedef enum logic [3:0] {
        C_IDLE = 4'h1,
        C_WR   = 4'h2,
        C_RD   = 4'h4,
        C_SKIP = 4'h8
    } sdc_cst_t;
endpackage

// file: sdc_link_if.sv
interface sdc_link_if;
    import sdc_pkg::*;
    logic                  ck;
    logic                  ck_n;
    logic                  cke;
    logic                  cs_n;
    logic                  ras_n;
    logic                  cas_n;
    logic                  we_n;
    logic [BA_W-1:0]       ba;
    logic [ADDR_W-1:0]     addr;
    logic                  termination_enable;
    logic                  write_mask;
    logic                  rst_n;
    logic [DQ_W-1:0]       ctl_dq_o;
    logic                  ctl_dq_oe;
    logic                  ctl_dqs_o;
    logic                  ctl_dqs_oe;
    logic [DQ_W-1:0]       dev_dq_o;
    logic                  dev_dq_oe;
    logic                  dev_dqs_o;
    logic                  dev_dqs_oe;
    logic                  termination_strobe;
    logic [DQ_W-1:0]       dq;
    logic                  dqs;
    assign ck_n = ~ck;
    assign dq   = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
    assign dqs  = dev_dqs_oe ? dev_dqs_o : (ctl_dqs_oe ? ctl_dqs_o : 1'b0);
    modport dev (
        input  ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
        input  termination_enable, write_mask, rst_n, dq, dqs,
        output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe, termination_strobe
    );
    modport ctl (
        output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
        output termination_enable, write_mask, rst_n,
        output ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_oe,
        input  dq, dqs, termination_strobe
    );
endinterface

// file: sdc_dram_end.sv
// Decided for this implementation: the address-and-strobe port and the address map.
module sdc_dram_end #(
    parameter int ROW_W = 3,
    parameter int COL_W = 3
) (
    input  wire logic                      mclk,
    input  wire logic                      sys_rst,
    input  wire logic                      clk_en,
    sdc_link_if.dev                        link,
    output wire logic                      term_on,
    output wire logic                      tstrb_on,
    output wire sdc_pkg::sdc_pwr_t         pwr_state,
    output wire logic [sdc_pkg::BANKS-1:0] bank_open,
    output wire logic                      burst_active
);
    import sdc_pkg::*;
    localparam int IN_W  = 10 + BA_W + ADDR_W + DQ_W;
    localparam int MEM_D = BANKS << (ROW_W + COL_W);
    localparam int IDX_W = BA_W + ROW_W + COL_W;

    typedef struct packed {
        logic [IN_W-1:0]                   s1;
        logic [IN_W-1:0]                   s2;
        logic                              ck_prev;
        sdc_pwr_t                          pwr;
        logic [BANKS-1:0]                  open;
        logic [BANKS-1:0][ROW_W-1:0]       row;
        logic [MR_NUM-1:0][ADDR_W-1:0]     mr;
        logic                              term_reg;
        logic                              busy;
        logic                              rd;
        logic                              ap;
        logic [3:0]                        left;
        logic [BA_W-1:0]                   bank;
        logic [COL_W-1:0]                  col;
        logic [DQ_W-1:0]                   dq_o;
        logic                              dq_oe;
        logic                              dqs_o;
    } sdc_dev_st_t;

    localparam sdc_dev_st_t ST_RST = '{pwr: PW_ON, mr: {MR_NUM{MR_RST}}, default: '0};

    sdc_dev_st_t      st_ff;
    sdc_dev_st_t      nxt_st;
    logic [DQ_W-1:0]  mem [MEM_D];
    logic             wr_en;
    logic [IDX_W-1:0] idx;
    logic [IN_W-1:0]  pins;

    logic             p_rst_n;
    logic             p_ck;
    logic             p_cke;
    logic             p_cs_n;
    logic [2:0]       p_cmd;
    logic             p_term;
    logic             p_mask;
    logic [BA_W-1:0]  p_ba;
    logic [ADDR_W-1:0] p_addr;
    logic [DQ_W-1:0]  p_dq;
    logic             ck_rise;
    logic             all_idle;
    logic             tstrb_en;
    logic [3:0]       bl;

    // reset and clock share the synchroniser so every edge sees one snapshot
    assign pins = {link.rst_n, link.ck, link.cke, link.cs_n, link.ras_n, link.cas_n,
                   link.we_n, link.termination_enable, link.write_mask, link.dqs,
                   link.ba, link.addr, link.dq};
    assign {p_rst_n, p_ck, p_cke, p_cs_n, p_cmd, p_term, p_mask} = st_ff.s2[IN_W-1 -: 9];
    assign {p_ba, p_addr, p_dq} = st_ff.s2[BA_W+ADDR_W+DQ_W-1:0];

    assign ck_rise  = p_ck & ~st_ff.ck_prev;
    assign all_idle = ~|st_ff.open;
    assign tstrb_en = st_ff.mr[1][MR1_TSTRB_BIT];
    assign idx      = {st_ff.bank, st_ff.row[st_ff.bank], st_ff.col};

    always_comb begin
        bl = BURST_OF_EIGHT;
        case (st_ff.mr[0][MR0_BL_LSB +: 2])
            BL_FIXED_CHOP: bl = CHOP_OF_FOUR;
            BL_ON_THE_FLY: bl = p_addr[BURST_CHOP_ADDR_BIT] ? BURST_OF_EIGHT
                                                              : CHOP_OF_FOUR;
            default:       bl = BURST_OF_EIGHT;
        endcase
    end

    always_comb begin
        nxt_st         = st_ff;
        wr_en          = 1'b0;
        nxt_st.s1      = pins;
        nxt_st.s2      = st_ff.s1;
        nxt_st.ck_prev = p_ck;
        if (!p_rst_n) begin
            // acts on every mclk, no link clock edge needed
            nxt_st         = ST_RST;
            nxt_st.s1      = pins;
            nxt_st.s2      = st_ff.s1;
            nxt_st.ck_prev = p_ck;
        end else begin
            if (st_ff.pwr == PW_SELF && p_cke) begin
                nxt_st.pwr = PW_ON;
            end
            if (ck_rise) begin
                // self refresh keeps the termination buffer off
                if (st_ff.pwr == PW_SELF) begin
                    nxt_st.term_reg = 1'b0;
                end else begin
                    nxt_st.term_reg = p_term;
                end
                if (st_ff.busy) begin
                    nxt_st.left = st_ff.left - 4'h1;
                    nxt_st.col  = st_ff.col + 1'b1;
                    if (st_ff.rd) begin
                        nxt_st.dq_o  = mem[idx];
                        nxt_st.dq_oe = 1'b1;
                        nxt_st.dqs_o = ~st_ff.dqs_o;
                    end else begin
                        // mask ball is no mask once it serves as termination strobe
                        wr_en = ~(p_mask & ~tstrb_en);
                    end
                    if (st_ff.left == 4'h1) begin
                        nxt_st.busy = 1'b0;
                        if (st_ff.ap) begin
                            nxt_st.open[st_ff.bank] = 1'b0;
                        end
                    end
                end else begin
                    nxt_st.dq_oe = 1'b0;
                    nxt_st.dqs_o = 1'b0;
                end
                if (st_ff.pwr == PW_ON) begin
                    if (!p_cke) begin
                        if (!p_cs_n && p_cmd == CMD_REFRESH && all_idle) begin
                            nxt_st.pwr = PW_SELF;
                        end else if (all_idle) begin
                            nxt_st.pwr = PW_PRE_PD;
                        end else begin
                            nxt_st.pwr = PW_ACT_PD;
                        end
                    end else if (!p_cs_n && !st_ff.busy) begin
                        case (p_cmd)
                            CMD_ACTIVATE: begin
                                nxt_st.open[p_ba] = 1'b1;
                                nxt_st.row[p_ba]  = p_addr[ROW_W-1:0];
                            end
                            CMD_READ, CMD_WRITE: begin
                                nxt_st.busy = 1'b1;
                                nxt_st.rd   = (p_cmd == CMD_READ);
                                nxt_st.bank = p_ba;
                                nxt_st.col  = p_addr[COL_W-1:0];
                                nxt_st.ap   = p_addr[AUTO_PRECHARGE_ADDR_BIT];
                                nxt_st.left = bl;
                            end
                            CMD_PRECHARGE: begin
                                if (p_addr[AUTO_PRECHARGE_ADDR_BIT]) begin
                                    nxt_st.open = '0;
                                end else begin
                                    nxt_st.open[p_ba] = 1'b0;
                                end
                            end
                            CMD_MODE_LOAD: begin
                                if (!p_ba[BA_W-1]) begin
                                    nxt_st.mr[p_ba[1:0]] = p_addr;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end else if (st_ff.pwr != PW_SELF && p_cke) begin
                    nxt_st.pwr = PW_ON;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_ff <= ST_RST;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge mclk) begin
        if (clk_en && !sys_rst && wr_en) begin
            mem[idx] <= p_dq;
        end
    end

    // termination only while mode enables it, and off in self refresh from the rise after the entry rise
    assign term_on  = st_ff.term_reg & st_ff.mr[1][MR1_TERM_BIT];
    assign tstrb_on = tstrb_en;
    assign link.termination_strobe = tstrb_en & term_on;
    assign link.dev_dq_o   = st_ff.dq_o;
    assign link.dev_dq_oe  = st_ff.dq_oe;
    assign link.dev_dqs_o  = st_ff.dqs_o;
    assign link.dev_dqs_oe = st_ff.dq_oe;
    assign pwr_state    = st_ff.pwr;
    assign bank_open    = st_ff.open;
    assign burst_active = st_ff.busy;
endmodule

// file: sdc_ctl_end.sv
module sdc_ctl_end (
    input  wire logic                               mclk,
    input  wire logic                               sys_rst,
    input  wire logic                               clk_en,
    sdc_link_if.ctl                                 link,
    input  wire logic                               cmd_valid,
    output wire logic                               cmd_ready,
    input  wire logic [2:0]                         cmd_code,
    input  wire logic [sdc_pkg::BA_W-1:0]           cmd_bank,
    input  wire logic [sdc_pkg::ADDR_W-1:0]         cmd_addr,
    input  wire logic [sdc_pkg::MAX_BL*sdc_pkg::DQ_W-1:0] wr_data,
    input  wire logic [sdc_pkg::MAX_BL-1:0]         wr_mask,
    input  wire logic                               gate_low_req,
    input  wire logic                               term_req,
    input  wire logic                               mem_rst_req,
    output wire logic [sdc_pkg::MAX_BL*sdc_pkg::DQ_W-1:0] rd_data,
    output wire logic                               rd_valid
);
    import sdc_pkg::*;
    typedef struct packed {
        logic [2:0]                  div;
        logic                        ck;
        sdc_cst_t                    cst;
        logic [1:0]                  blf;
        logic [3:0]                  left;
        logic [2:0]                  beat;
        logic [MAX_BL*DQ_W-1:0]      wbuf;
        logic [MAX_BL-1:0]           mbuf;
        logic [MAX_BL*DQ_W-1:0]      rbuf;
        logic                        rvalid;
        logic [DQ_W-1:0]             s1;
        logic [DQ_W-1:0]             s2;
        logic                        cke;
        logic                        cs_n;
        logic [2:0]                  cmd;
        logic [BA_W-1:0]             ba;
        logic [ADDR_W-1:0]           addr;
        logic                        term;
        logic                        mask;
        logic                        rst_n;
        logic [DQ_W-1:0]             dq_o;
        logic                        dq_oe;
    } sdc_ctl_st_t;

    localparam sdc_ctl_st_t ST_RST = '{cst: C_IDLE, cmd: CMD_NOP, default: '0};
    localparam logic [2:0]  DIV_END = 3'(CK_HALF_CYC - 1);

    sdc_ctl_st_t st_ff;
    sdc_ctl_st_t nxt_st;
    logic        wrap;
    logic        fall;
    logic        rise;
    logic [3:0]  bl;

    assign wrap      = (st_ff.div == DIV_END);
    assign fall      = wrap & st_ff.ck;
    assign rise      = wrap & ~st_ff.ck;
    assign cmd_ready = fall & (st_ff.cst == C_IDLE);

    always_comb begin
        bl = BURST_OF_EIGHT;
        case (st_ff.blf)
            BL_FIXED_CHOP: bl = CHOP_OF_FOUR;
            BL_ON_THE_FLY: bl = cmd_addr[BURST_CHOP_ADDR_BIT] ? BURST_OF_EIGHT
                                                                : CHOP_OF_FOUR;
            default:       bl = BURST_OF_EIGHT;
        endcase
    end

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.s1     = link.dq;
        nxt_st.s2     = st_ff.s1;
        nxt_st.rvalid = 1'b0;
        nxt_st.div    = wrap ? 3'h0 : st_ff.div + 3'h1;
        if (wrap) begin
            nxt_st.ck = ~st_ff.ck;
        end
        // pins move on the falling edge so the device sees them settled at the rise
        if (fall) begin
            nxt_st.cke   = ~gate_low_req;
            nxt_st.term  = term_req;
            nxt_st.rst_n = ~mem_rst_req;
            nxt_st.cs_n  = 1'b0;
            nxt_st.cmd   = CMD_NOP;
            nxt_st.dq_oe = 1'b0;
            nxt_st.mask  = 1'b0;
            case (st_ff.cst)
                C_IDLE: begin
                    if (cmd_valid) begin
                        nxt_st.cmd  = cmd_code;
                        nxt_st.ba   = cmd_bank;
                        nxt_st.addr = cmd_addr;
                        nxt_st.left = bl;
                        nxt_st.beat = 3'h0;
                        nxt_st.wbuf = wr_data;
                        nxt_st.mbuf = wr_mask;
                        if (cmd_code == CMD_MODE_LOAD && cmd_bank == 3'h0) begin
                            nxt_st.blf = cmd_addr[MR0_BL_LSB +: 2];
                        end
                        if (cmd_code == CMD_WRITE) begin
                            nxt_st.cst = C_WR;
                        end else if (cmd_code == CMD_READ) begin
                            nxt_st.cst = C_SKIP;
                        end
                    end
                end
                C_WR: begin
                    nxt_st.dq_oe = 1'b1;
                    nxt_st.dq_o  = st_ff.wbuf[st_ff.beat*DQ_W +: DQ_W];
                    nxt_st.mask  = st_ff.mbuf[st_ff.beat];
                    nxt_st.beat  = st_ff.beat + 3'h1;
                    nxt_st.left  = st_ff.left - 4'h1;
                    if (st_ff.left == 4'h1) begin
                        nxt_st.cst = C_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
        if (rise) begin
            case (st_ff.cst)
                // first beat is captured only at the third rise after launch, so two rises are skipped
                C_SKIP: begin
                    nxt_st.beat = st_ff.beat + 3'h1;
                    if (st_ff.beat == 3'h1) begin
                        nxt_st.cst  = C_RD;
                        nxt_st.beat = 3'h0;
                    end
                end
                C_RD: begin
                    nxt_st.rbuf[st_ff.beat*DQ_W +: DQ_W] = st_ff.s2;
                    nxt_st.beat = st_ff.beat + 3'h1;
                    nxt_st.left = st_ff.left - 4'h1;
                    if (st_ff.left == 4'h1) begin
                        nxt_st.cst    = C_IDLE;
                        nxt_st.rvalid = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_ff <= ST_RST;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign link.ck                 = st_ff.ck;
    assign link.cke                = st_ff.cke;
    assign link.cs_n               = st_ff.cs_n;
    assign {link.ras_n, link.cas_n, link.we_n} = st_ff.cmd;
    assign link.ba                 = st_ff.ba;
    assign link.addr               = st_ff.addr;
    assign link.termination_enable = st_ff.term;
    assign link.write_mask         = st_ff.mask;
    assign link.rst_n              = st_ff.rst_n;
    assign link.ctl_dq_o           = st_ff.dq_o;
    assign link.ctl_dq_oe          = st_ff.dq_oe;
    // strobe follows the clock: rising edges land mid-beat, falling edges land with each new beat
    assign link.ctl_dqs_o          = st_ff.ck;
    assign link.ctl_dqs_oe         = st_ff.dq_oe;
    assign rd_data                 = st_ff.rbuf;
    assign rd_valid                = st_ff.rvalid;
endmodule

// file: sdc_link_checker.sv
module sdc_link_checker (
    input wire logic                       mclk,
    input wire logic                       sys_rst,
    input wire logic                       ck,
    input wire logic                       cke,
    input wire logic                       cs_n,
    input wire logic                       ras_n,
    input wire logic                       cas_n,
    input wire logic                       we_n,
    input wire logic [sdc_pkg::BA_W-1:0]   ba,
    input wire logic [sdc_pkg::ADDR_W-1:0] addr,
    input wire logic                       write_mask,
    input wire logic                       rst_n,
    input wire logic [sdc_pkg::DQ_W-1:0]   ctl_dq_o,
    input wire logic                       ctl_dq_oe,
    input wire logic                       ctl_dqs_oe,
    input wire logic                       dev_dq_oe,
    input wire logic                       dev_dqs_o,
    input wire logic                       dev_dqs_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    import sdc_pkg::*;
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    property p_rank_on;
        cs_n == 1'b0;
    endproperty
    a_rank_on: assert property (p_rank_on) else $error("rank select left high");
    property p_ck_high;
        $rose(ck) |-> ck [*4] ##1 !ck;
    endproperty
    a_ck_high: assert property (p_ck_high) else $error("link clock high phase");
    property p_ck_low;
        $fell(ck) |-> !ck [*4] ##1 ck;
    endproperty
    a_ck_low: assert property (p_ck_low) else $error("link clock low phase");
    // a change away from a fall could be caught at a rise by the device
    property p_fall_only;
        $changed({cke, rst_n, ras_n, cas_n, we_n, ba, addr, write_mask, ctl_dq_oe}) |-> $fell(ck);
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("command moved off a fall");
    property p_no_clash;
        !(dev_dq_oe && ctl_dq_oe) && !(dev_dqs_oe && ctl_dqs_oe);
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
    property p_read_strobe;
        $rose(dev_dq_oe) |-> dev_dqs_oe && dev_dqs_o;
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("read strobe not aligned");
    property p_beat_hold;
        $rose(ctl_dq_oe) |=> (ctl_dq_oe && $stable(ctl_dq_o) && $stable(write_mask)) [*7];
    endproperty
    a_beat_hold: assert property (p_beat_hold) else $error("write beat too short");
    property p_read_lat;
        $fell(ck) && !cs_n && cke && rst_n && {ras_n, cas_n, we_n} == CMD_READ
            |-> ##[12:18] $rose(dev_dq_oe);
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read data late");
endmodule

// file: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sdc_pkg::*;
    logic              mclk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              cv = 1'b0;
    logic              glr = 1'b0;
    logic              trq = 1'b0;
    logic              mrr = 1'b0;
    logic [2:0]        code = 3'h7;
    logic [BA_W-1:0]   bank = 3'h0;
    logic [ADDR_W-1:0] adr = 14'h0000;
    logic [63:0]       wd = 64'h0;
    logic [7:0]        wm = 8'h00;
    logic [31:0]       rnd = 32'h0001_3bad;
    logic [7:0]        mem[int];
    int                orow[8];
    int                n_errors = 0;
    int                checks = 0;
    wire logic         cr, rv, ton, tso, bact;
    wire logic [63:0]  rd;
    wire logic [7:0]   bo;
    wire sdc_pwr_t     ps;
    sdc_link_if link();
    always #10 mclk = ~mclk;
    sdc_ctl_end sdc_ctl_end_i(.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .link(link.ctl),
        .cmd_valid(cv), .cmd_ready(cr), .cmd_code(code), .cmd_bank(bank), .cmd_addr(adr),
        .wr_data(wd), .wr_mask(wm), .gate_low_req(glr), .term_req(trq),
        .mem_rst_req(mrr), .rd_data(rd), .rd_valid(rv));
    sdc_dram_end #(.ROW_W(3), .COL_W(3)) sdc_dram_end_i(.mclk(mclk), .sys_rst(sys_rst),
        .clk_en(1'b1), .link(link.dev), .term_on(ton), .tstrb_on(tso), .pwr_state(ps),
        .bank_open(bo), .burst_active(bact));
    sdc_link_checker sdc_link_checker_i(.mclk(mclk), .sys_rst(sys_rst), .ck(link.ck),
        .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
        .we_n(link.we_n), .ba(link.ba), .addr(link.addr), .write_mask(link.write_mask),
        .rst_n(link.rst_n), .ctl_dq_o(link.ctl_dq_o), .ctl_dq_oe(link.ctl_dq_oe),
        .ctl_dqs_oe(link.ctl_dqs_oe), .dev_dq_oe(link.dev_dq_oe),
        .dev_dqs_o(link.dev_dqs_o), .dev_dqs_oe(link.dev_dqs_oe));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // ready is sampled before the edge's updates land, as the taking edge sees it
    task automatic issue(input logic [2:0] c, input int b, input logic [ADDR_W-1:0] a);
        int n;
        n = 0;
        @(posedge mclk);
        cv <= 1'b1;
        code <= c;
        bank <= b[BA_W-1:0];
        adr <= a;
        @(posedge mclk);
        while (cr !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 400) n_errors++;
        cv <= 1'b0;
    endtask
    task automatic wr(input int b, input logic [2:0] col, input logic chop, input logic [7:0] m);
        logic [63:0] d;
        rnd = lfsr(rnd);
        d[31:0] = rnd;
        rnd = lfsr(rnd);
        d[63:32] = rnd;
        wd <= d;
        wm <= m;
        for (int i = 0; i < (chop ? 4 : 8); i++)
            if (!m[i]) mem[b * 64 + orow[b] * 8 + ((col + i) & 7)] = d[8 * i +: 8];
        issue(CMD_WRITE, b, {1'b0, ~chop, 9'h000, col});
    endtask
    task automatic rdc(input int b, input logic [2:0] col, input logic chop, input logic ap);
        logic [63:0] e;
        logic [63:0] k;
        int          n;
        e = 64'h0;
        k = 64'h0;
        n = 0;
        issue(CMD_READ, b, {1'b0, ~chop, 1'b0, ap, 7'h00, col});
        cyc(16);
        chk(bact, 1'b1);
        for (int i = 0; i < (chop ? 4 : 8); i++) begin
            e[8 * i +: 8] = mem[b * 64 + orow[b] * 8 + ((col + i) & 7)];
            k[8 * i +: 8] = 8'hff;
        end
        while (rv !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 400) n_errors++;
        chk(rd & k, e);
    endtask
    task automatic pd(input sdc_pwr_t e);
        glr <= 1'b1;
        cyc(32);
        chk(ps, e);
        glr <= 1'b0;
        cyc(32);
        chk(ps, PW_ON);
    endtask
    initial begin
        cyc(2);
        sys_rst <= 1'b0;
        issue(CMD_MODE_LOAD, 0, {12'h000, BL_ON_THE_FLY});
        issue(CMD_MODE_LOAD, 1, 14'h0004);
        for (int b = 0; b < 8; b++) begin
            rnd = lfsr(rnd);
            orow[b] = rnd[2:0];
            issue(CMD_ACTIVATE, b, {11'h000, rnd[2:0]});
        end
        cyc(16);
        chk(bo, 8'hff);
        $display("test activate done");
        for (int b = 0; b < 8; b++) begin
            wr(b, 3'h0, 1'b0, 8'h00);
            rnd = lfsr(rnd);
            wr(b, rnd[5:3], rnd[6], rnd[15:8]);
            rdc(b, 3'h0, 1'b0, 1'b0);
            rdc(b, rnd[10:8], rnd[7], 1'b0);
        end
        $display("test write read done");
        issue(CMD_PRECHARGE, 3, 14'h0000);
        cyc(16);
        chk(bo, 8'hf7);
        rdc(5, 3'h0, 1'b0, 1'b1);
        cyc(16);
        chk(bo, 8'hd7);
        pd(PW_ACT_PD);
        issue(CMD_PRECHARGE, 0, 14'h0400);
        cyc(16);
        chk(bo, 8'h00);
        pd(PW_PRE_PD);
        // gate must drop at the very fall that carries the refresh
        while (cr !== 1'b1) begin
            @(posedge mclk);
        end
        glr <= 1'b1;
        issue(CMD_REFRESH, 0, 14'h0000);
        cyc(32);
        chk(ps, PW_SELF);
        glr <= 1'b0;
        cyc(32);
        chk(ps, PW_ON);
        $display("test precharge power done");
        trq <= 1'b1;
        cyc(32);
        chk(ton, 1'b1);
        issue(CMD_MODE_LOAD, 1, 14'h0804);
        cyc(32);
        chk(tso, 1'b1);
        chk(link.termination_strobe, 1'b1);
        issue(CMD_MODE_LOAD, 1, 14'h0000);
        cyc(32);
        chk(ton, 1'b0);
        trq <= 1'b0;
        issue(CMD_ACTIVATE, 2, 14'h0001);
        cyc(16);
        chk(bo, 8'h04);
        mrr <= 1'b1;
        cyc(32);
        chk(bo, 8'h00);
        mrr <= 1'b0;
        cyc(32);
        $display("test termination reset done");
        final_report;
    end
    initial begin
        #1000000;
        n_errors++;
        final_report;
    end
endmodule
